//--- ads_pkg.sv
package ads_pkg;

  // core clock rate and conversion timing
  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;
  localparam int CONV_TIME_NS = 1600;
  localparam int CODE_W = 16;
  localparam int IDX_W = 4;
  localparam int CNT_W = 5;
  localparam int TMR_W = 8;
  localparam int STEP_TIME_NS = CONV_TIME_NS / CODE_W;
  // one successive-approximation step, rounded up to whole cycles
  localparam int STEP_CYCLES =
    (STEP_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int CONV_CYCLES = STEP_CYCLES * CODE_W;

  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(STEP_CYCLES - 1);

  // output code points, straight binary
  localparam logic [CODE_W-1:0] ZERO_CODE = 16'h0000;
  localparam logic [CODE_W-1:0] MID_CODE = 16'h8000;
  localparam logic [CODE_W-1:0] FULL_CODE = 16'hFFFF;
  localparam logic [CODE_W-1:0] BIT0_CODE = 16'h0001;

  localparam logic [IDX_W-1:0] MSB_IDX = 4'hF;
  localparam logic [IDX_W-1:0] LSB_IDX = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;

  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;

  typedef enum logic [1:0] {
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10
  } ads_st_t;

  function automatic logic [CNT_W-1:0] ads_gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

//--- ads_cnt_if.sv
interface ads_cnt_if;
  import ads_pkg::*;
  // gray-coded count of serial clock falling edges
  logic [CNT_W-1:0] gray;
  modport src (output gray);
  modport dst (input gray);
endinterface

//--- ads_sync.sv
module ads_sync
  import ads_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ads_sync_st_t;

  ads_sync_st_t q, d;

  always_comb begin
    d = q;
    d.meta = i_d;
    d.stable = q.meta;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.stable;

endmodule // ads_sync

//--- ads_edge_cnt.sv
module ads_edge_cnt
  import ads_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_reset_n,
  ads_cnt_if.src o_cnt
);

  typedef struct packed {
    logic [CNT_W-1:0] bin;
    logic [CNT_W-1:0] gray;
  } ads_cnt_st_t;

  ads_cnt_st_t q, d;
  logic [CNT_W-1:0] bin_next;

  // free-running count; the core takes a base at each frame start, so no
  // per-frame reset is needed while this clock stands still
  always_comb begin
    d = q;
    bin_next = q.bin + CNT_ONE;
    d.bin = bin_next;
    d.gray = bin_next ^ (bin_next >> 1);
  end

  always_ff @(negedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_cnt.gray = q.gray;

endmodule // ads_edge_cnt

//--- ads_top.sv
module ads_top
  import ads_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_convert_strobe,
  input wire logic [CODE_W-1:0] i_sample_code,
  input wire logic i_over_range,
  output logic o_serial_result_out,
  output logic o_serial_result_oe_n,
  output logic o_powered_up
);

  typedef struct packed {
    ads_st_t st;
    logic [CODE_W-1:0] sample;
    logic [CODE_W-1:0] sar;
    logic [CODE_W-1:0] result;
    logic [IDX_W-1:0] bit_idx;
    logic [TMR_W-1:0] timer;
    logic cnv_prev;
    logic [CNT_W-1:0] base;
    logic oe_n;
    logic serial_result_out;
    logic pwr;
  } ads_top_st_t;

  localparam ads_top_st_t RESET_ST = '{
    st: ST_ACQ,
    sample: ZERO_CODE,
    sar: ZERO_CODE,
    result: ZERO_CODE,
    bit_idx: MSB_IDX,
    timer: TMR_ZERO,
    cnv_prev: 1'b0,
    base: CNT_ZERO,
    oe_n: 1'b1,
    serial_result_out: 1'b0,
    pwr: 1'b0
  };

  localparam int CONV_MAX = CONV_CYCLES + 2;

  ads_top_st_t q, d;
  ads_cnt_if cnt_if ();

  logic cnv_s;
  logic [CNT_W-1:0] gray_s;
  logic [CNT_W-1:0] cnt_bin;
  logic [CNT_W-1:0] rd_idx;
  logic [CODE_W-1:0] trial;
  logic [CODE_W-1:0] sar_next;
  logic rise_w;
  logic fall_w;
  logic finish_w;

  ads_edge_cnt u_edge_cnt (
    .i_sclk (i_sclk),
    .i_reset_n (i_reset_n),
    .o_cnt (cnt_if.src)
  );

  ads_sync #(.W(1)) u_sync_cnv (
    .i_clk (i_mclk),
    .i_reset_n (i_reset_n),
    .i_d (i_convert_strobe),
    .o_q (cnv_s)
  );

  // gray code lets the multi-bit count cross with at most one bit moving
  ads_sync #(.W(CNT_W)) u_sync_cnt (
    .i_clk (i_mclk),
    .i_reset_n (i_reset_n),
    .i_d (cnt_if.gray),
    .o_q (gray_s)
  );

  always_comb begin
    d = q;
    rise_w = cnv_s & ~q.cnv_prev;
    fall_w = ~cnv_s & q.cnv_prev;
    cnt_bin = ads_gray2bin(gray_s);
    rd_idx = cnt_bin - q.base;
    trial = q.sar | (BIT0_CODE << q.bit_idx);
    sar_next = (trial <= q.sample) ? trial : q.sar;
    finish_w = (q.st == ST_CONV) && (q.timer == STEP_LAST) &&
               (q.bit_idx == LSB_IDX) && !rise_w;
    d.cnv_prev = cnv_s;

    // conversion paced by the core clock only
    case (q.st)
      ST_ACQ: begin
        d.pwr = 1'b0;
      end
      ST_CONV: begin
        if (q.timer == STEP_LAST) begin
          d.timer = TMR_ZERO;
          d.sar = sar_next;
          if (q.bit_idx == LSB_IDX) begin
            d.st = ST_ACQ;
            d.result = sar_next;
            d.pwr = 1'b0;
          end else begin
            d.bit_idx = q.bit_idx - IDX_ONE;
          end
        end else begin
          d.timer = q.timer + TMR_ONE;
        end
      end
      default: begin
        d.st = ST_ACQ;
      end
    endcase

    // a new edge restarts even a conversion in progress
    if (rise_w) begin
      d.st = ST_CONV;
      d.sample = i_over_range ? FULL_CODE : i_sample_code;
      d.sar = ZERO_CODE;
      d.bit_idx = MSB_IDX;
      d.timer = TMR_ZERO;
      d.pwr = 1'b1;
    end

    // readout; the result word is quasi-static once conversion is done
    if (cnv_s) begin
      d.oe_n = 1'b1;
      d.serial_result_out = 1'b0;
    end else if (fall_w) begin
      d.oe_n = 1'b0;
      d.base = cnt_bin;
      d.serial_result_out = q.result[MSB_IDX];
    end else begin
      d.oe_n = 1'b0;
      if (rd_idx < FRAME_BITS) begin
        d.serial_result_out = q.result[MSB_IDX - rd_idx[IDX_W-1:0]];
      end else begin
        d.serial_result_out = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= RESET_ST;
    end else begin
      q <= d;
    end
  end

  assign o_serial_result_out = q.serial_result_out;
  assign o_serial_result_oe_n = q.oe_n;
  assign o_powered_up = q.pwr;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  a_conv_start: assert property (
    rise_w |=> (q.st == ST_CONV) && q.pwr && (q.bit_idx == MSB_IDX)
  ) else $error("conversion did not start on strobe rise");

  a_out_release: assert property (
    rise_w |=> o_serial_result_oe_n
  ) else $error("output not released on strobe rise");

  a_auto_pwrdn: assert property (
    finish_w |=> (q.st == ST_ACQ) && !o_powered_up
  ) else $error("no return to acquisition after conversion");

  a_conv_bounded: assert property (
    (rise_w ##1 !rise_w [*8]) |-> ##[1:CONV_MAX] (q.st == ST_ACQ) || rise_w
  ) else $error("conversion ran past its time");

  a_msb_first: assert property (
    fall_w |=> !o_serial_result_oe_n &&
               (o_serial_result_out == $past(q.result[MSB_IDX]))
  ) else $error("msb not presented at strobe fall");

  a_bit_advance: assert property (
    (!cnv_s && !fall_w && (rd_idx < FRAME_BITS)) |=>
      o_serial_result_out ==
        $past(q.result[MSB_IDX - rd_idx[IDX_W-1:0]])
  ) else $error("serial bit does not follow edge count");

  a_bit_stable: assert property (
    (!cnv_s && $past(!cnv_s, 2) && $past(!cnv_s) && $stable(gray_s) &&
     $stable(q.result) && $stable(q.base)) |=> $stable(o_serial_result_out)
  ) else $error("serial bit moved without a clock edge");

  a_oe_strobe_low: assert property (
    !o_serial_result_oe_n |-> $past(!cnv_s)
  ) else $error("output driven while strobe high");

  a_no_sclk_needed: assert property (
    ((q.st == ST_CONV) && !rise_w) |=>
      (q.timer != $past(q.timer)) || (q.st == ST_ACQ)
  ) else $error("conversion stalled");

  a_sar_exact: assert property (
    finish_w |=> q.result == $past(q.sample)
  ) else $error("result differs from sampled code");

  a_over_sat: assert property (
    (rise_w && i_over_range) |=> q.sample == FULL_CODE
  ) else $error("over-range did not saturate");

  a_oe_strobe_high: assert property (
    cnv_s |=>
      o_serial_result_oe_n
  ) else $error("output enabled while strobe high");

  a_oe_strobe_fall: assert property (
    !cnv_s |=>
      !o_serial_result_oe_n
  ) else $error("output not enabled while strobe low");

  a_sdo_parked: assert property (
    o_serial_result_oe_n |->
      !o_serial_result_out
  ) else $error("released output not parked low");

  a_pwr_rise_start: assert property (
    $rose(o_powered_up) |->
      $past(rise_w)
  ) else $error("power up without strobe rise");

  a_pwr_fall_end: assert property (
    $fell(o_powered_up) |->
      $past(finish_w)
  ) else $error("power down before conversion end");

  a_pwr_conv: assert property (
    (q.st == ST_CONV) |->
      o_powered_up
  ) else $error("powered down while converting");

  a_pwr_acq: assert property (
    (q.st == ST_ACQ) |->
      !o_powered_up
  ) else $error("powered up in acquisition");

  a_acq_stays: assert property (
    ((q.st == ST_ACQ) && !rise_w) |=>
      (q.st == ST_ACQ)
  ) else $error("left acquisition without strobe rise");

  a_state_onehot: assert property (
    $onehot(q.st)
  ) else $error("state code not one-hot");

  a_conv_cleared: assert property (
    rise_w |=>
      (q.sar == ZERO_CODE) && (q.timer == TMR_ZERO)
  ) else $error("conversion started with stale trial state");

  a_sample_hold: assert property (
    ((q.st == ST_CONV) && !rise_w) |=>
      $stable(q.sample)
  ) else $error("sample moved during conversion");

  a_step_pace: assert property (
    ((q.st == ST_CONV) && (q.timer != STEP_LAST) && !rise_w) |=>
      (q.timer == $past(q.timer) + TMR_ONE)
  ) else $error("step timer did not advance");

  a_step_hold: assert property (
    ((q.st == ST_CONV) && (q.timer != STEP_LAST) && !rise_w) |=>
      $stable(q.sar) && $stable(q.bit_idx)
  ) else $error("trial state moved inside a step");

  a_bit_step: assert property (
    ((q.st == ST_CONV) && (q.timer == STEP_LAST) &&
     (q.bit_idx != LSB_IDX) && !rise_w) |=>
      (q.bit_idx == $past(q.bit_idx) - IDX_ONE) && (q.timer == TMR_ZERO)
  ) else $error("trial bit did not step down");

  a_sar_bound: assert property (
    (q.st == ST_CONV) |->
      (q.sar <= q.sample)
  ) else $error("trial value above sampled code");

  a_result_hold: assert property (
    !((q.st == ST_CONV) && (q.timer == STEP_LAST) &&
      (q.bit_idx == LSB_IDX)) |=>
      $stable(q.result)
  ) else $error("result changed outside conversion end");

  a_base_take: assert property (
    fall_w |=>
      (q.base == $past(cnt_bin))
  ) else $error("frame base not taken at strobe fall");

  a_tail_zero: assert property (
    (!cnv_s && !fall_w && (rd_idx >= FRAME_BITS)) |=>
      !o_serial_result_out
  ) else $error("bits past the frame not zero");

endmodule // ads_top

//--- ads_host_model.sv
module ads_host_model (
  input wire logic i_mclk,
  input wire logic i_lclk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n,
  output logic o_convert_strobe,
  output logic o_sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_convert_strobe = 1'b0;
    o_sclk = 1'b0;
  end
  // no busy flag exists, so the host simply waits out the conversion
  task automatic convert(input int hold);
    @(negedge i_mclk) o_convert_strobe = 1'b1;
    repeat (hold) @(negedge i_mclk);
  endtask
  // lower the strobe for a while without clocking any bit out
  task automatic pause(input int low);
    @(negedge i_mclk) o_convert_strobe = 1'b0;
    repeat (low) @(negedge i_mclk);
  endtask
  // sample at each rising edge, confirm the bit still holds at the fall
  task automatic read_frame(output logic [15:0] word, output logic held);
    logic mid;
    held = 1'b1;
    @(negedge i_mclk) o_convert_strobe = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (10) @(posedge i_lclk);
      o_sclk = 1'b1;
      // a released line reads as the inverse, so a late enable shows up
      word[i] = i_sdo_oe_n ? ~i_sdo : i_sdo;
      mid = i_sdo;
      repeat (4) @(posedge i_lclk);
      if (i_sdo !== mid || i_sdo_oe_n !== 1'b0) begin
        held = 1'b0;
      end
      o_sclk = 1'b0;
    end
  endtask
endmodule // ads_host_model

//--- adc_conversion_serial_readout_bench.sv
module adc_conversion_serial_readout_bench;
  import ads_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic reset_n = 1'b0;
  logic over_range = 1'b0;
  logic [CODE_W-1:0] sample_code = ZERO_CODE;
  logic strobe, sclk, serial_result_out, sdo_oe_n, powered_up;
  int fail_count = 0;
  int n_checks = 0;

  always #5 mclk = ~mclk;
  // link clock offset so its edges drift against the core clock
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end

  ads_top dut_u (
    .i_mclk(mclk),
    .i_reset_n(reset_n),
    .i_sclk(sclk),
    .i_convert_strobe(strobe),
    .i_sample_code(sample_code),
    .i_over_range(over_range),
    .o_serial_result_out(serial_result_out),
    .o_serial_result_oe_n(sdo_oe_n),
    .o_powered_up(powered_up)
  );

  ads_host_model host_u (
    .i_mclk(mclk),
    .i_lclk(lclk),
    .i_sdo(serial_result_out),
    .i_sdo_oe_n(sdo_oe_n),
    .o_convert_strobe(strobe),
    .o_sclk(sclk)
  );

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // convert, watch each phase, then read the frame back
  task automatic cycle(input logic [15:0] code, input logic ovr,
                       input logic [15:0] exp);
    logic [15:0] word;
    logic held;
    @(negedge mclk);
    sample_code = code;
    over_range = ovr;
    host_u.convert(6);
    chk("oe_n converting", 16'h0001, {15'h0000, sdo_oe_n});
    chk("powered converting", 16'h0001, {15'h0000, powered_up});
    host_u.convert(150);
    chk("powered sclk idle", 16'h0001, {15'h0000, powered_up});
    host_u.convert(14);
    chk("powered after", 16'h0000, {15'h0000, powered_up});
    // a late input change must not leak into the latched sample
    sample_code = ~code;
    over_range = 1'b0;
    host_u.read_frame(word, held);
    chk("result", exp, word);
    chk("bit hold", 16'h0001, {15'h0000, held});
    repeat (6) @(negedge mclk);
    chk("tail bit", 16'h0000, {15'h0000, serial_result_out});
    chk("oe_n reading", 16'h0000, {15'h0000, sdo_oe_n});
  endtask

  task automatic t_code_points;
    logic [15:0] codes [6];
    codes = '{ZERO_CODE, BIT0_CODE, 16'h7FFF, MID_CODE, 16'hA5C3,
              FULL_CODE};
    foreach (codes[i]) begin
      cycle(codes[i], 1'b0, codes[i]);
    end
    $display("test code_points done");
  endtask

  task automatic t_over_range;
    cycle(16'h1234, 1'b1, FULL_CODE);
    cycle(MID_CODE, 1'b0, MID_CODE);
    $display("test over_range done");
  endtask

  // a second strobe rise mid-conversion restarts with the new sample
  task automatic t_restart;
    logic [15:0] word;
    logic held;
    sample_code = 16'h3C5A;
    host_u.convert(40);
    host_u.pause(4);
    chk("oe_n strobe low", 16'h0000, {15'h0000, sdo_oe_n});
    chk("powered strobe low", 16'h0001, {15'h0000, powered_up});
    // the previous result (midscale) stands while converting
    chk("early msb", 16'h0001, {15'h0000, serial_result_out});
    sample_code = 16'hC3A5;
    host_u.convert(140);
    chk("powered restart", 16'h0001, {15'h0000, powered_up});
    host_u.convert(30);
    chk("powered restart end", 16'h0000, {15'h0000, powered_up});
    host_u.read_frame(word, held);
    chk("restart result", 16'hC3A5, word);
    chk("restart hold", 16'h0001, {15'h0000, held});
    $display("test restart done");
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    t_code_points;
    t_over_range;
    t_restart;
    conclude;
  end

  // the run needs about 3000 cycles; this allows ample slack
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    conclude;
  end
endmodule // adc_conversion_serial_readout_bench
